// file: logic/apo_pkg.sv
// Constants shared by the converter output port and its sample FIFO
package apo_pkg;
  // Result word width
  localparam int unsigned CODE_W      = 8;
  // Width of the digitised input level and of the two reference levels
  localparam int unsigned LEVEL_W     = 10;
  // Depth of the sample FIFO
  localparam int unsigned FIFO_DEPTH  = 16;
  // Width of the FIFO fill count
  localparam int unsigned COUNT_W     = $clog2(FIFO_DEPTH) + 1;
  // Clamp codes
  localparam logic [CODE_W-1:0] CODE_ZERO = 8'h00;
  localparam logic [CODE_W-1:0] CODE_FULL = 8'hff;
  // Reset value of the output word
  localparam logic [CODE_W-1:0] DATA_RST  = 8'h00;
  // Pipeline delay in half sample-clock cycles (2.5 cycles)
  localparam int unsigned PIPE_HALF_CYCLES = 5;
  // Words held while a result waits for its rising edge: captures on the
  // falling edges, release on the rising edge 2.5 cycles later
  localparam logic [COUNT_W-1:0] PIPE_WORDS =
    COUNT_W'((PIPE_HALF_CYCLES + 1) / 2);
  // System clock period and the output delay behind a pipeline release
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned OUT_DELAY_NS   = 100;
  // Longest delay, rounded down, never below one cycle
  localparam int unsigned OUT_DELAY_CYC  =
    (OUT_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 : (OUT_DELAY_NS / CLK_PERIOD_NS);
endpackage

// file: logic/apo_fifo.sv
// Sample FIFO with registered read data, parameterised in width and depth
`timescale 1ns/100ps
module apo_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  output logic [$clog2(DEPTH):0]          count
);
  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];          // Storage array
  logic [PW-1:0]    wr_ptr_r;             // Write pointer
  logic [PW-1:0]    rd_ptr_r;             // Read pointer
  logic [PW:0]      count_r;              // Fill level
  logic             push;                 // Accepted write
  logic             pop;                  // Accepted read

  // Handshake terms; full and empty come straight from the fill level
  assign in_ready  = (count_r != (PW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign count     = count_r;

  // Write port
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Read data register, follows the head slot one cycle late
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_data <= '0;
    end else begin
      out_data <= mem[rd_ptr_r];
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= PW'(wr_ptr_r + 1'b1);
      end
      if (pop) begin
        rd_ptr_r <= PW'(rd_ptr_r + 1'b1);
      end
      if (push && !pop) begin
        count_r <= (PW+1)'(count_r + 1'b1);
      end else if (pop && !push) begin
        count_r <= (PW+1)'(count_r - 1'b1);
      end
    end
  end
endmodule

// file: logic/apo_port.sv
// Converter output port: sampling, code clamping, fixed latency, output drive
`timescale 1ns/100ps

module apo_port (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          sample_clk,
  input  wire logic [apo_pkg::LEVEL_W-1:0]   sample_level,
  input  wire logic [apo_pkg::LEVEL_W-1:0]   reference_top_level,
  input  wire logic [apo_pkg::LEVEL_W-1:0]   reference_bottom_level,
  input  wire logic                          output_enable_n,
  output logic [apo_pkg::CODE_W-1:0]         data_out,
  output logic [apo_pkg::CODE_W-1:0]         data_oe,
  output logic                               data_update,
  output logic                               capture_lost
);
  import apo_pkg::*;

  // Sample clock history for edge detection
  logic                 sample_clk_r;
  // Edge strobes of the sample clock
  logic                 fall_edge;
  logic                 rise_edge;
  // Converted code of the present input level
  logic [CODE_W-1:0]    conv_code;
  // Scaled in-range code, wide enough for the product
  logic [LEVEL_W+CODE_W-1:0] scaled;
  // Offset above the bottom level and span of the ladder
  logic [LEVEL_W-1:0]   offset_lvl;
  logic [LEVEL_W-1:0]   span_lvl;
  // FIFO handshake
  logic                 fifo_in_ready;
  logic                 fifo_out_valid;
  logic                 fifo_pop;
  logic [CODE_W-1:0]    fifo_rd_data;
  logic [COUNT_W-1:0]   fifo_count;
  logic                 push;

  // Remember the last sample clock level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_clk_r <= 1'b0;
    end else begin
      sample_clk_r <= sample_clk;
    end
  end

  // A falling edge starts a conversion; a rising edge releases a result
  assign fall_edge = sample_clk_r && !sample_clk;
  assign rise_edge = !sample_clk_r && sample_clk;

  // Ladder geometry
  assign offset_lvl = LEVEL_W'(sample_level - reference_bottom_level);
  assign span_lvl   = LEVEL_W'(reference_top_level - reference_bottom_level);

  // Quantiser: clamps first, then straight binary scaling
  always_comb begin
    scaled    = '0;
    conv_code = CODE_ZERO;
    if (sample_level < reference_bottom_level) begin
      // Below the ladder
      conv_code = CODE_ZERO;
    end else if (sample_level >= reference_top_level) begin
      // At or above the top saturates
      conv_code = CODE_FULL;
    end else begin
      // Span is nonzero here since bottom <= level < top
      // Operands widened first so the product keeps all its bits
      scaled    = ((LEVEL_W+CODE_W)'(offset_lvl) * (LEVEL_W+CODE_W)'(CODE_FULL))
                  / (LEVEL_W+CODE_W)'(span_lvl);
      conv_code = CODE_W'(scaled);
    end
  end

  // A falling edge pushes its code while the FIFO has room, whatever the output enable says
  assign push = fall_edge && fifo_in_ready;

  // Pop on a rising edge once the pipeline is primed, fixing the latency
  assign fifo_pop = rise_edge && fifo_out_valid && (fifo_count >= PIPE_WORDS);

  // Pipeline storage between capture and output
  apo_fifo #(
    .WIDTH (CODE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (fall_edge),
    .in_ready  (fifo_in_ready),
    .in_data   (conv_code),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_rd_data),
    .count     (fifo_count)
  );

  // Output word register, updated once per released result
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= DATA_RST;
    end else if (fifo_pop) begin
      // Head word, registered one output delay behind the release
      data_out <= fifo_rd_data;
    end
  end

  // One-cycle strobe marking a new word on the bus
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_update <= 1'b0;
    end else begin
      data_update <= fifo_pop;
    end
  end

  // Per-pin drive enables follow the active-low output enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_oe <= '0;
    end else if (!output_enable_n) begin
      // Drive every data line
      data_oe <= '1;
    end else begin
      // Release every data line
      data_oe <= '0;
    end
  end

  // Sticky flag: a capture found the FIFO full and was dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_lost <= 1'b0;
    end else if (fall_edge && !fifo_in_ready) begin
      capture_lost <= 1'b1;
    end
  end

  // Helper: codes of the last three captures, newest first
  logic [CODE_W-1:0] code_h0_r;  // Newest capture
  logic [CODE_W-1:0] code_h1_r;  // One capture older
  logic [CODE_W-1:0] code_h2_r;  // Two captures older, head when three held
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_h0_r <= '0;
      code_h1_r <= '0;
      code_h2_r <= '0;
    end else if (push) begin
      // Shift on every accepted capture
      code_h0_r <= conv_code;
      code_h1_r <= code_h0_r;
      code_h2_r <= code_h1_r;
    end
  end

  // Falling edge is taken into the FIFO on the same clock
  a_capture_edge: assert property (@(posedge clk) disable iff (!rst_n)
    (fall_edge && fifo_in_ready) |=> (fifo_count == $past(fifo_count) + 1'b1 - $past(fifo_pop)))
    else $error("falling edge not captured");

  // Below bottom reference converts to zero
  a_clamp_low: assert property (@(posedge clk) disable iff (!rst_n)
    (sample_level < reference_bottom_level) |-> (conv_code == 8'h00))
    else $error("low clamp code wrong");

  // Above top reference converts to all ones
  a_clamp_high: assert property (@(posedge clk) disable iff (!rst_n)
    (sample_level > reference_top_level) |-> (conv_code == 8'hff))
    else $error("high clamp code wrong");

  // Bottom level itself gives zero whenever the top lies above it
  a_code_bottom: assert property (@(posedge clk) disable iff (!rst_n)
    (sample_level == reference_bottom_level && span_lvl != '0) |-> (conv_code == 8'h00))
    else $error("bottom code not zero");

  // Enable low drives all lines on the next edge
  a_oe_drive: assert property (@(posedge clk) disable iff (!rst_n)
    !output_enable_n |=> (data_oe == 8'hff))
    else $error("outputs not driven");

  // Enable high floats the lines but captures keep going
  a_oe_float: assert property (@(posedge clk) disable iff (!rst_n)
    (output_enable_n && fall_edge && fifo_in_ready) |=> (data_oe == 8'h00) && !capture_lost)
    else $error("float or capture wrong");

  // Primed pipeline releases on the rising edge and shows it next cycle
  a_latency_pop: assert property (@(posedge clk) disable iff (!rst_n)
    (rise_edge && fifo_count == 3) |=> data_update && (data_out == $past(fifo_rd_data)))
    else $error("result not released at latency");

  // Steady stream: a result is never released before three are held
  a_pipe_depth: assert property (@(posedge clk) disable iff (!rst_n)
    (rise_edge && fifo_count < 3) |=> !data_update)
    else $error("released too early");

  // Released word is the capture three back, all eight bits intact
  a_code_width: assert property (@(posedge clk) disable iff (!rst_n)
    (fifo_pop && fifo_count == 3) |=> (data_out == $past(code_h2_r)))
    else $error("released word differs from capture");

  // A new word is flagged for one cycle only
  a_update_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    data_update |=> !data_update)
    else $error("update strobe longer than one cycle");

  // No rising sample edge, no new word
  a_halt_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !rise_edge |=> !data_update)
    else $error("word released without sample edge");

  // Output word holds between releases
  a_word_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !fifo_pop |=> $stable(data_out))
    else $error("output word changed without release");

  c_release:    cover property (@(posedge clk) disable iff (!rst_n) data_update);
  c_clamp_full: cover property (@(posedge clk) disable iff (!rst_n)
    push && conv_code == 8'hff);
  c_clamp_zero: cover property (@(posedge clk) disable iff (!rst_n)
    push && conv_code == 8'h00);
  c_float_cap:  cover property (@(posedge clk) disable iff (!rst_n)
    (output_enable_n && push) ##[1:16] data_update);
endmodule

// file: verif/apo_capture_model.sv
// Capture-side model: makes the sample clock and parks it low
`timescale 1ns/100ps
module apo_capture_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [3:0] half_cyc,
  output logic            sample_clk
);
  logic [3:0] cnt_r;  // Clocks left in this phase
  // Toggle every half_cyc clocks, one clock per phase at the fastest
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r      <= 4'h0;
      sample_clk <= 1'b0;
    end else if (cnt_r > 4'h1) begin
      cnt_r <= cnt_r - 4'h1;
    end else if (run || sample_clk) begin
      sample_clk <= ~sample_clk;
      cnt_r      <= (half_cyc == 4'h0) ? 4'h1 : half_cyc;
    end
  end
endmodule

// file: verif/apo_port_tb.sv
// Self-checking bench for the converter output port
`timescale 1ns/100ps
module apo_port_tb;
  import apo_pkg::*;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               run = 1'b0;
  logic [3:0]         half_cyc = 4'h1;
  logic               sample_clk;
  logic [LEVEL_W-1:0] sample_level = '0;
  logic [LEVEL_W-1:0] top_lvl = 10'h384;
  logic [LEVEL_W-1:0] bot_lvl = 10'h064;
  logic               output_enable_n = 1'b0;
  logic [CODE_W-1:0]  data_out;
  logic [CODE_W-1:0]  data_oe;
  logic               data_update;
  logic               capture_lost;
  int                 miscompares = 0;
  int                 num_checks = 0;
  int                 words = 0;    // New words seen
  int                 lv_mode = 0;  // Nonzero: levels from boundary table
  bit                 oe_rand = 0;  // Toggle the drive enable at random
  bit                 prev_sclk = 0;
  bit                 oen_q = 0;
  bit                 armed = 0;
  int                 exp_q[$];     // Codes captured, not yet shown
  int                 lv_tab[9];

  always #50 clk = ~clk;

  apo_capture_model partner (.clk(clk), .rst_n(rst_n), .run(run), .half_cyc(half_cyc),
                             .sample_clk(sample_clk));
  apo_port uut (.clk(clk), .rst_n(rst_n), .sample_clk(sample_clk),
                .sample_level(sample_level), .reference_top_level(top_lvl),
                .reference_bottom_level(bot_lvl), .output_enable_n(output_enable_n),
                .data_out(data_out), .data_oe(data_oe), .data_update(data_update),
                .capture_lost(capture_lost));

  // Reference code of one level
  function automatic int code_of(int lv, int bt, int tp);
    if (lv < bt) return 0;
    if (lv >= tp) return 255;
    return (lv - bt) * 255 / (tp - bt);
  endfunction

  // One comparison
  task automatic chk(string what, logic [7:0] got, logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Wait for n more words, bounded
  task automatic wait_words(int n);
    int target;
    int guard;
    target = words + n;
    guard = 0;
    while (words < target && guard < 3000) begin
      @(posedge clk);
      guard++;
    end
    if (words < target) begin
      miscompares++;
      $display("Error at %0t ns: words got %h expected %h", $time, words, target);
      finish_test();
    end
  endtask

  // Random levels and drive enable, changed on the rising edge
  always @(posedge clk) begin
    sample_level <= (lv_mode != 0) ? 10'(lv_tab[$urandom % 9]) : 10'($urandom);
    if (oe_rand && ($urandom % 4 == 0)) output_enable_n <= ~output_enable_n;
  end

  // Model: capture on falls, compare each new word, watch the drive enable
  always @(posedge clk) begin
    if (!rst_n) begin
      armed = 0;
      prev_sclk = 0;
      exp_q.delete();
    end else begin
      if (armed) chk("drive", data_oe, oen_q ? 8'h00 : 8'hff);
      if (data_update === 1'b1) begin
        words++;
        chk("word", data_out, exp_q.size() > 0 ? 8'(exp_q.pop_front()) : 8'hxx);
        chk("in flight", 8'(exp_q.size()), 8'h02);
      end
      if (prev_sclk && !sample_clk) exp_q.push_back(code_of(sample_level, bot_lvl, top_lvl));
      prev_sclk = sample_clk;
      oen_q = output_enable_n;
      armed = 1;
    end
  end

  // Main sequence
  initial begin
    int b;
    int n;
    logic [7:0] held;
    void'($urandom(18));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // Look before the first edge after release loads the drive enable
    #1;
    chk("reset word", data_out, DATA_RST);
    chk("reset drive", data_oe, 8'h00);
    chk("reset strobe", 8'(data_update), 8'h00);
    // Fastest stream, outputs driven
    @(posedge clk);
    run <= 1'b1;
    wait_words(40);
    $display("Test fast stream done");
    // Slow stream, random references, drive enable toggling
    b = $urandom % 400;
    @(posedge clk);
    half_cyc <= 4'h3;
    bot_lvl <= 10'(b);
    top_lvl <= 10'(b + 100 + $urandom % 500);
    oe_rand <= 1'b1;
    wait_words(30);
    $display("Test slow stream done");
    // Levels at and around both references
    lv_tab = '{0, 99, 100, 101, 500, 899, 900, 901, 1023};
    @(posedge clk);
    bot_lvl <= 10'h064;
    top_lvl <= 10'h384;
    half_cyc <= 4'h2;
    lv_mode <= 1;
    wait_words(40);
    $display("Test clamp codes done");
    // Halted clock freezes the output
    @(posedge clk);
    run <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    n = words;
    held = data_out;
    repeat (30) @(posedge clk);
    #1;
    chk("halt words", 8'(words - n), 8'h00);
    chk("halt hold", data_out, held);
    @(posedge clk);
    run <= 1'b1;
    wait_words(10);
    chk("lost flag", 8'(capture_lost), 8'h00);
    $display("Test halt and restart done");
    finish_test();
  end
endmodule
